// file: core/dtf_pkg.sv
// Functional notes
// - 3Xh writes 1-256 sectors; long, no-retry bits
// - Seek implicitly when target differs from position (format 50h never seeks here)
// - Long write: one sector plus four check bytes
// - Interrupt per later sector; first via request flag
// - Base segment writes; invalidate touched cache segments
// - Linear mode: address from cylinder, sector, head
// - Drive/head: ones 7,5; linear 6; drive 4
// - 40h/41h verify sectors without host data
// - Verify: active segment, other segments, then seek
// - 50h: 512-byte table, count matches geometry
// - Flags: 00 good, 80 bad, 20 unassign, 40 reassign
// - Format zeroes data; undescribed sectors untouched
// - Interrupt when format finishes
// - Linear format: count blocks, ids relative
// - 7Xh: busy, start seek, interrupt at once
// - Seek-complete on arrival; accept commands early
// - Seek keeps cache segments valid
// - Self-test result codes 01-05, 8x slave
// - Master waits 5 s for pass line
// - 90h runs in both; drive bit reads 0
// - 91h sets sectors-per-track and head count
// - Sector count zero means 256
// - Command write sets busy immediately
package dtf_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [5:0] IDX_DATA = 6'h00;
	localparam logic [5:0] IDX_ERROR = 6'h01;
	localparam logic [5:0] IDX_SECCNT = 6'h02;
	localparam logic [5:0] IDX_SECNUM = 6'h03;
	localparam logic [5:0] IDX_CYLLO = 6'h04;
	localparam logic [5:0] IDX_CYLHI = 6'h05;
	localparam logic [5:0] IDX_SDH = 6'h06;
	localparam logic [5:0] IDX_STATUS = 6'h07;
	localparam logic [5:0] IDX_LAST = 6'h07;
	// Command codes
	localparam logic [3:0] OPC_WRITE_HI = 4'h3;
	localparam logic [6:0] OPC_VERIFY_HI = 7'h20;
	localparam logic [7:0] OPC_FORMAT = 8'h50;
	localparam logic [3:0] OPC_SEEK_HI = 4'h7;
	localparam logic [7:0] OPC_DIAG = 8'h90;
	localparam logic [7:0] OPC_SETP = 8'h91;
	localparam int CMD_LONG_BIT = 1;
	localparam int CMD_NORETRY_BIT = 0;
	// Drive/head register layout
	localparam int SDH_LBA_BIT = 6;
	localparam int SDH_DEV_BIT = 4;
	localparam logic [7:0] SDH_FIXED = 8'ha0;
	// Status bits
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_SC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	// Error register values
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] ERR_MEDIA = 8'h40;
	localparam logic [7:0] DIAG_PASS = 8'h01;
	localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;
	// Format table flag bytes
	localparam logic [7:0] FLAG_GOOD = 8'h00;
	localparam logic [7:0] FLAG_BAD = 8'h80;
	localparam logic [7:0] FLAG_UNASSIGN = 8'h20;
	localparam logic [7:0] FLAG_REASSIGN = 8'h40;
	// Transfer sizes in 16-bit words; the zero-count value is in sectors
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [8:0] ECC_WORDS = 9'h002;
	localparam logic [8:0] TABLE_WORDS = 9'h100;
	localparam logic [8:0] COUNT_ZERO_MEANS = 9'h100;
	// Timing
	localparam longint CLK_HZ = 40000000;
	localparam longint PASS_WAIT_MS = 5000;
	localparam longint PASS_WAIT_CYC = PASS_WAIT_MS * CLK_HZ / 1000;
	localparam int PASS_CNT_W = 28;
	// Reset values
	localparam logic [7:0] SPT_RESET = 8'h3f;
	localparam logic [4:0] HEADS_RESET = 5'h10;

	typedef enum logic [1:0] {MOP_WRITE, MOP_VERIFY, MOP_FORMAT} dtf_mop_t;
	typedef enum logic [1:0] {FMT_GOOD, FMT_BAD, FMT_UNASSIGN, FMT_REASSIGN} dtf_fmt_t;
	typedef enum logic [1:0] {CR_HIT, CR_ACTIVE_MISS, CR_OTHER_HIT, CR_MISS} dtf_cres_t;

	typedef struct packed {
		logic lba_mode;
		logic [3:0] head;
		logic [15:0] cyl;
		logic [7:0] sector;
	} dtf_addr_t;

	typedef struct packed {
		dtf_mop_t op;
		dtf_addr_t addr;
		logic [8:0] count;
		logic [8:0] idx;
		logic long_mode;
		logic no_retry;
	} dtf_job_t;
endpackage : dtf_pkg

// file: core/dtf_cmd.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dtf_cmd
	import dtf_pkg::*;
#(
	parameter longint PASS_WAIT = PASS_WAIT_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Host interrupt line
	output logic INTRQ,
	// Job description shared by media, seek and cache
	output dtf_job_t JOB,
	output logic MED_REQ,
	input wire logic MED_DONE,
	input wire logic MED_ERR,
	output logic SEEK_REQ,
	input wire logic SEEK_DONE,
	output logic CACHE_INV,
	output logic CACHE_QUERY,
	input wire logic CACHE_ACK,
	input wire dtf_cres_t CACHE_RES,
	// Base segment write port
	output logic BUF_WE,
	output logic [8:0] BUF_WADDR,
	output logic [15:0] BUF_WDATA,
	// Format table entries
	output logic FMT_VALID,
	output dtf_fmt_t FMT_ACTION,
	output logic [7:0] FMT_SECTOR,
	// Self-test engine
	output logic DIAG_REQ,
	input wire logic DIAG_DONE,
	input wire logic [7:0] DIAG_CODE,
	// Geometry
	output logic [7:0] SECTORS_PER_TRACK,
	output logic [4:0] HEADS,
	// Pass line and role strap
	input wire logic PASS_IN,
	output logic PASS_OUT,
	output logic PASS_OE_N,
	input wire logic IS_SLAVE
);
	typedef enum {S_IDLE, S_DECODE, S_SEEK, S_DRQ, S_MEDIA, S_QUERY, S_DIAG, S_PASS} dtf_state_t;

	dtf_state_t state;
	logic [7:0] seccnt, secnum, cyllo, cylhi, drive_head_select_register, err_reg, opcode;
	logic busy, drq, sc, err_flag;
	logic [8:0] wcnt;
	logic [19:0] cur_pos;
	logic pos_valid;
	logic [7:0] diag_own;
	logic [PASS_CNT_W-1:0] pass_cnt;
	logic pass_meta, pass_sync, slave_meta, slave_sync;

	logic [5:0] aidx;
	logic mapped, wr_acc, rd_acc, rd_setup, cmd_take, data_take;
	logic [8:0] count9, wlimit;
	dtf_addr_t tgt;
	logic [19:0] tgt_pos;
	logic pos_differs, selected, fmt_id_ok;
	logic [7:0] fmt_lim;
	logic [7:0] status;

	// Bus decode
	assign aidx = PADDR[7:2];
	assign mapped = (PADDR[1:0] == 2'b00) && (aidx <= IDX_LAST);
	assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
	assign rd_acc = PSEL && PENABLE && !PWRITE && mapped;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// Only the addressed drive takes commands, except self-test
	assign selected = (drive_head_select_register[SDH_DEV_BIT] == slave_sync) || (PWDATA[7:0] == OPC_DIAG);
	assign cmd_take = wr_acc && (aidx == IDX_STATUS) && !busy && selected;
	assign data_take = wr_acc && (aidx == IDX_DATA) && drq;

	assign count9 = (seccnt == 8'h00) ? COUNT_ZERO_MEANS : {1'b0, seccnt};
	assign tgt.lba_mode = drive_head_select_register[SDH_LBA_BIT];
	assign tgt.head = drive_head_select_register[3:0];
	assign tgt.cyl = {cylhi, cyllo};
	assign tgt.sector = secnum;
	// Linear mode keys on the 20 upper block bits, geometry on cylinder and head
	assign tgt_pos = tgt.lba_mode ? {drive_head_select_register[3:0], cylhi, cyllo[7:0]} : {cylhi, cyllo, drive_head_select_register[3:0]};
	assign pos_differs = !pos_valid || (tgt_pos != cur_pos);
	assign wlimit = (state == S_DRQ && JOB.op == MOP_FORMAT) ? TABLE_WORDS
		: (JOB.long_mode ? SECTOR_WORDS + ECC_WORDS : SECTOR_WORDS);

	assign status = {busy, 1'b1, 1'b0, sc, drq, 1'b0, 1'b0, err_flag};

	// Pin synchronisers
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			pass_meta <= 1'b1;
			pass_sync <= 1'b1;
			slave_meta <= 1'b0;
			slave_sync <= 1'b0;
		end else begin
			pass_meta <= PASS_IN;
			pass_sync <= pass_meta;
			slave_meta <= IS_SLAVE;
			slave_sync <= slave_meta;
		end
	end

	// Read data, latched in the setup phase; busy hides other registers
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			PRDATA <= 32'h0;
		end else if (rd_setup) begin
			PRDATA <= 32'h0;
			if (busy && aidx != IDX_STATUS) begin
				PRDATA[7:0] <= status;
			end else begin
				case (aidx)
					IDX_ERROR: PRDATA[7:0] <= err_reg;
					IDX_SECCNT: PRDATA[7:0] <= seccnt;
					IDX_SECNUM: PRDATA[7:0] <= secnum;
					IDX_CYLLO: PRDATA[7:0] <= cyllo;
					IDX_CYLHI: PRDATA[7:0] <= cylhi;
					IDX_SDH: PRDATA[7:0] <= drive_head_select_register;
					IDX_STATUS: PRDATA[7:0] <= status;
					default: PRDATA[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// Task file registers, writable while idle
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			seccnt <= 8'h01;
			secnum <= 8'h01;
			cyllo <= 8'h00;
			cylhi <= 8'h00;
			drive_head_select_register <= SDH_FIXED;
		end else if (wr_acc && !busy) begin
			case (aidx)
				IDX_SECCNT: seccnt <= PWDATA[7:0];
				IDX_SECNUM: secnum <= PWDATA[7:0];
				IDX_CYLLO: cyllo <= PWDATA[7:0];
				IDX_CYLHI: cylhi <= PWDATA[7:0];
				IDX_SDH: drive_head_select_register <= PWDATA[7:0] | SDH_FIXED;
				default: ;
			endcase
		end else if (state == S_DECODE && opcode == OPC_DIAG) begin
			drive_head_select_register[SDH_DEV_BIT] <= 1'b0;
		end
	end

	// Interrupt: events set it, status read or new command clears; set wins
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			INTRQ <= 1'b0;
		end else if ((state == S_DECODE && opcode[7:4] == OPC_SEEK_HI)
			|| (state == S_MEDIA && MED_DONE)
			|| (state == S_QUERY && CACHE_ACK && CACHE_RES == CR_HIT)
			|| (state == S_DIAG && DIAG_DONE && slave_sync)
			|| (state == S_PASS && (!pass_sync || pass_cnt == PASS_CNT_W'(PASS_WAIT)))
			|| (state == S_DECODE && opcode != OPC_DIAG && opcode[7:4] != OPC_SEEK_HI
				&& opcode[7:4] != OPC_WRITE_HI && opcode[7:1] != OPC_VERIFY_HI
				&& opcode != OPC_FORMAT && opcode != OPC_SETP)
			|| (state == S_DECODE && opcode[7:4] == OPC_WRITE_HI && opcode[CMD_LONG_BIT] && count9 != 9'h001)
			|| (state == S_DECODE && opcode == OPC_FORMAT && !drive_head_select_register[SDH_LBA_BIT] && seccnt != SECTORS_PER_TRACK)) begin
			INTRQ <= 1'b1;
		end else if ((rd_acc && aidx == IDX_STATUS) || cmd_take) begin
			INTRQ <= 1'b0;
		end
	end

	// Seek-complete flag follows the actuator at any time
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			sc <= 1'b1;
		end else if (SEEK_DONE) begin
			sc <= 1'b1;
		end else if (SEEK_REQ) begin
			sc <= 1'b0;
		end
	end

	// Base segment and format table stream
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			wcnt <= 9'h0;
			BUF_WE <= 1'b0;
			BUF_WADDR <= 9'h0;
			BUF_WDATA <= 16'h0;
			FMT_VALID <= 1'b0;
			FMT_ACTION <= FMT_GOOD;
			FMT_SECTOR <= 8'h0;
		end else begin
			BUF_WE <= data_take;
			FMT_VALID <= 1'b0;
			if (!drq) begin
				wcnt <= 9'h0;
			end else if (data_take) begin
				wcnt <= wcnt + 9'h1;
				BUF_WADDR <= wcnt;
				BUF_WDATA <= PWDATA[15:0];
				if (JOB.op == MOP_FORMAT) begin
					FMT_VALID <= fmt_id_ok;
					FMT_SECTOR <= PWDATA[15:8];
					case (PWDATA[7:0])
						FLAG_BAD: FMT_ACTION <= FMT_BAD;
						FLAG_UNASSIGN: FMT_ACTION <= FMT_UNASSIGN;
						FLAG_REASSIGN: FMT_ACTION <= FMT_REASSIGN;
						default: FMT_ACTION <= FMT_GOOD;
					endcase
					if (PWDATA[7:0] != FLAG_GOOD && PWDATA[7:0] != FLAG_BAD
						&& PWDATA[7:0] != FLAG_UNASSIGN && PWDATA[7:0] != FLAG_REASSIGN) begin
						FMT_VALID <= 1'b0;
					end
				end
			end
		end
	end

	// Table ids run 1..SECTORS_PER_TRACK, or 1..block count in linear mode
	assign fmt_lim = JOB.addr.lba_mode ? JOB.count[7:0] - 8'h1 + 8'h1 : SECTORS_PER_TRACK;
	assign fmt_id_ok = (PWDATA[15:8] != 8'h00)
		&& ((JOB.addr.lba_mode && JOB.count[8]) || PWDATA[15:8] <= fmt_lim);

	// Command sequencer
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			state <= S_IDLE;
			opcode <= 8'h00;
			busy <= 1'b0;
			drq <= 1'b0;
			err_flag <= 1'b0;
			err_reg <= DIAG_PASS;
			JOB <= '0;
			MED_REQ <= 1'b0;
			SEEK_REQ <= 1'b0;
			CACHE_INV <= 1'b0;
			CACHE_QUERY <= 1'b0;
			DIAG_REQ <= 1'b0;
			cur_pos <= 20'h0;
			pos_valid <= 1'b0;
			SECTORS_PER_TRACK <= SPT_RESET;
			HEADS <= HEADS_RESET;
			diag_own <= DIAG_PASS;
			pass_cnt <= '0;
			PASS_OUT <= 1'b1;
			PASS_OE_N <= 1'b1;
		end else begin
			MED_REQ <= 1'b0;
			SEEK_REQ <= 1'b0;
			CACHE_INV <= 1'b0;
			CACHE_QUERY <= 1'b0;
			DIAG_REQ <= 1'b0;
			case (state)
				S_IDLE: begin
					if (cmd_take) begin
						opcode <= PWDATA[7:0];
						busy <= 1'b1;
						err_flag <= 1'b0;
						state <= S_DECODE;
					end
				end
				S_DECODE: begin
					JOB.addr <= tgt;
					JOB.count <= count9;
					JOB.idx <= 9'h0;
					JOB.long_mode <= opcode[CMD_LONG_BIT];
					JOB.no_retry <= opcode[CMD_NORETRY_BIT];
					if (opcode[7:4] == OPC_WRITE_HI) begin
						JOB.op <= MOP_WRITE;
						if (opcode[CMD_LONG_BIT] && count9 != 9'h001) begin
							err_reg <= ERR_ABORT;
							err_flag <= 1'b1;
							busy <= 1'b0;
							state <= S_IDLE;
						end else begin
							CACHE_INV <= 1'b1;
							if (pos_differs) begin
								SEEK_REQ <= 1'b1;
								cur_pos <= tgt_pos;
								pos_valid <= 1'b1;
								state <= S_SEEK;
							end else begin
								drq <= 1'b1;
								state <= S_DRQ;
							end
						end
					end else if (opcode[7:1] == OPC_VERIFY_HI) begin
						JOB.op <= MOP_VERIFY;
						CACHE_QUERY <= 1'b1;
						state <= S_QUERY;
					end else if (opcode == OPC_FORMAT) begin
						JOB.op <= MOP_FORMAT;
						if (!drive_head_select_register[SDH_LBA_BIT] && seccnt != SECTORS_PER_TRACK) begin
							err_reg <= ERR_ABORT;
							err_flag <= 1'b1;
							busy <= 1'b0;
							state <= S_IDLE;
						end else begin
							drq <= 1'b1;
							state <= S_DRQ;
						end
					end else if (opcode[7:4] == OPC_SEEK_HI) begin
						SEEK_REQ <= 1'b1;
						cur_pos <= tgt_pos;
						pos_valid <= 1'b1;
						busy <= 1'b0;
						state <= S_IDLE;
					end else if (opcode == OPC_DIAG) begin
						DIAG_REQ <= 1'b1;
						PASS_OUT <= 1'b1;
						PASS_OE_N <= 1'b1;
						state <= S_DIAG;
					end else if (opcode == OPC_SETP) begin
						SECTORS_PER_TRACK <= seccnt;
						HEADS <= {1'b0, drive_head_select_register[3:0]} + 5'h1;
						busy <= 1'b0;
						state <= S_IDLE;
					end else begin
						err_reg <= ERR_ABORT;
						err_flag <= 1'b1;
						busy <= 1'b0;
						state <= S_IDLE;
					end
				end
				S_SEEK: begin
					if (SEEK_DONE) begin
						if (JOB.op == MOP_WRITE) begin
							drq <= 1'b1;
							state <= S_DRQ;
						end else begin
							MED_REQ <= 1'b1;
							state <= S_MEDIA;
						end
					end
				end
				S_DRQ: begin
					if (data_take && wcnt == wlimit - 9'h1) begin
						drq <= 1'b0;
						MED_REQ <= 1'b1;
						state <= S_MEDIA;
					end
				end
				S_QUERY: begin
					if (CACHE_ACK) begin
						case (CACHE_RES)
							CR_HIT: begin
								busy <= 1'b0;
								state <= S_IDLE;
							end
							CR_MISS: begin
								if (pos_differs) begin
									SEEK_REQ <= 1'b1;
									cur_pos <= tgt_pos;
									pos_valid <= 1'b1;
									state <= S_SEEK;
								end else begin
									MED_REQ <= 1'b1;
									state <= S_MEDIA;
								end
							end
							default: begin
								MED_REQ <= 1'b1;
								state <= S_MEDIA;
							end
						endcase
					end
				end
				S_MEDIA: begin
					if (MED_DONE) begin
						if (MED_ERR) begin
							err_reg <= ERR_MEDIA;
							err_flag <= 1'b1;
							busy <= 1'b0;
							state <= S_IDLE;
						end else if (JOB.op == MOP_WRITE && JOB.idx + 9'h1 != JOB.count) begin
							JOB.idx <= JOB.idx + 9'h1;
							drq <= 1'b1;
							state <= S_DRQ;
						end else begin
							busy <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
				S_DIAG: begin
					if (DIAG_DONE) begin
						diag_own <= DIAG_CODE;
						pass_cnt <= '0;
						if (slave_sync) begin
							err_reg <= DIAG_CODE;
							if (DIAG_CODE == DIAG_PASS) begin
								PASS_OUT <= 1'b0;
								PASS_OE_N <= 1'b0;
							end
							busy <= 1'b0;
							state <= S_IDLE;
						end else begin
							state <= S_PASS;
						end
					end
				end
				S_PASS: begin
					pass_cnt <= pass_cnt + 1'b1;
					if (!pass_sync) begin
						err_reg <= diag_own;
						busy <= 1'b0;
						state <= S_IDLE;
					end else if (pass_cnt == PASS_CNT_W'(PASS_WAIT)) begin
						err_reg <= DIAG_SLAVE_FAIL | diag_own;
						busy <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule : dtf_cmd
`default_nettype wire

// file: tb/dtf_mon_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dtf_mon
	import dtf_pkg::*;
(
	// Clock, reset and host bus
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic INTRQ,
	// Back-end side
	input wire dtf_job_t JOB,
	input wire logic MED_REQ,
	input wire logic MED_DONE,
	input wire logic SEEK_REQ,
	input wire logic CACHE_INV,
	input wire logic CACHE_ACK,
	input wire dtf_cres_t CACHE_RES,
	input wire logic BUF_WE,
	input wire logic FMT_VALID,
	input wire logic [7:0] FMT_SECTOR,
	input wire logic [7:0] SECTORS_PER_TRACK,
	input wire logic [4:0] HEADS,
	input wire logic PASS_OUT,
	input wire logic PASS_OE_N,
	input wire logic IS_SLAVE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	logic cmd_wr;
	logic seek_wr;
	logic wr_wr;
	assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == {IDX_STATUS, 2'b00};
	assign seek_wr = cmd_wr && PWDATA[7:4] == OPC_SEEK_HI;
	// Long writes may abort, so only short writes are held to the quiet start
	assign wr_wr = cmd_wr && PWDATA[7:4] == OPC_WRITE_HI && !PWDATA[CMD_LONG_BIT];
	a_cmd_irq_clear: assert property (cmd_wr |-> ##[1:2] !INTRQ)
		else $error("interrupt not cleared by command");
	a_seek_at_once: assert property (seek_wr |-> ##[1:3] (SEEK_REQ && INTRQ))
		else $error("seek did not start with interrupt");
	a_seek_keeps_cache: assert property (seek_wr |=> !CACHE_INV [*4])
		else $error("seek invalidated cache");
	a_write_inval: assert property (wr_wr |-> ##[1:3] CACHE_INV)
		else $error("write did not invalidate cache");
	a_first_quiet: assert property (wr_wr |-> ##3 !INTRQ [*8])
		else $error("interrupt before first sector");
	a_long_single: assert property (MED_REQ && JOB.op == MOP_WRITE && JOB.long_mode |-> JOB.count == 9'h001)
		else $error("long write with more than one sector");
	a_count_nonzero: assert property (MED_REQ |-> JOB.count != 9'h000)
		else $error("zero sector count reached media");
	a_verify_silent: assert property (JOB.op == MOP_VERIFY |-> !BUF_WE)
		else $error("verify moved host data");
	a_hit_no_media: assert property (CACHE_ACK && CACHE_RES == CR_HIT |=> !MED_REQ [*4])
		else $error("media read on cache hit");
	a_miss_media: assert property (CACHE_ACK && CACHE_RES inside {CR_ACTIVE_MISS, CR_OTHER_HIT}
		|-> ##[1:4] MED_REQ)
		else $error("no media read on partial miss");
	a_fmt_done_irq: assert property (MED_DONE && JOB.op == MOP_FORMAT |-> ##[1:3] INTRQ)
		else $error("format ended without interrupt");
	a_fmt_id_range: assert property (FMT_VALID && !JOB.addr.lba_mode
		|-> FMT_SECTOR != 8'h00 && FMT_SECTOR <= SECTORS_PER_TRACK)
		else $error("format entry outside track");
	a_heads_range: assert property (HEADS != 5'h00 && HEADS <= 5'h10)
		else $error("head count out of range");
	a_pass_slave: assert property (!PASS_OE_N |-> IS_SLAVE && !PASS_OUT)
		else $error("pass line driven wrongly");
endmodule : dtf_mon
bind dtf_cmd dtf_mon u_mon (.CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .INTRQ, .JOB,
	.MED_REQ, .MED_DONE, .SEEK_REQ, .CACHE_INV, .CACHE_ACK, .CACHE_RES, .BUF_WE, .FMT_VALID,
	.FMT_SECTOR, .SECTORS_PER_TRACK, .HEADS, .PASS_OUT, .PASS_OE_N, .IS_SLAVE);
`default_nettype wire

// file: tb/dtf_back.sv
`timescale 1ns/1ps
`default_nettype none
module dtf_back
	import dtf_pkg::*;
(
	// Clock, reset and reply control
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] dly,
	input wire dtf_cres_t cres,
	// Requests
	input wire logic med_req,
	input wire logic seek_req,
	input wire logic cache_query,
	input wire logic diag_req,
	input wire logic cache_inv,
	input wire logic buf_we,
	input wire logic fmt_valid,
	// Replies
	output logic med_done = 1'b0,
	output logic med_err,
	output logic seek_done = 1'b0,
	output logic cache_ack = 1'b0,
	output dtf_cres_t cache_res,
	output logic diag_done = 1'b0,
	output logic [7:0] diag_code,
	// Event counts
	output logic [31:0] n_med = 32'h0,
	output logic [31:0] n_seek = 32'h0,
	output logic [31:0] n_inv = 32'h0,
	output logic [31:0] n_we = 32'h0,
	output logic [31:0] n_fmt = 32'h0
);
	logic [3:0] c_med = 4'h0;
	logic [3:0] c_seek = 4'h0;
	logic [3:0] c_cq = 4'h0;
	logic [3:0] c_dg = 4'h0;
	function automatic logic [3:0] step(input logic req, input logic [3:0] c, input logic [3:0] d);
		return req ? d : c - {3'h0, c != 4'h0};
	endfunction : step
	// Each request is answered dly+1 cycles later; dly of zero is never answered
	always_ff @(posedge clk) begin
		c_med <= nrst ? step(med_req, c_med, dly) : 4'h0;
		c_seek <= nrst ? step(seek_req, c_seek, dly) : 4'h0;
		c_cq <= nrst ? step(cache_query, c_cq, dly) : 4'h0;
		c_dg <= nrst ? step(diag_req, c_dg, dly) : 4'h0;
		med_done <= nrst && c_med == 4'h1;
		seek_done <= nrst && c_seek == 4'h1;
		cache_ack <= nrst && c_cq == 4'h1;
		diag_done <= nrst && c_dg == 4'h1;
	end
	always_ff @(posedge clk) begin
		n_med <= nrst ? n_med + {31'h0, med_req} : 32'h0;
		n_seek <= nrst ? n_seek + {31'h0, seek_req} : 32'h0;
		n_inv <= nrst ? n_inv + {31'h0, cache_inv} : 32'h0;
		n_we <= nrst ? n_we + {31'h0, buf_we} : 32'h0;
		n_fmt <= nrst ? n_fmt + {31'h0, fmt_valid} : 32'h0;
	end
	// Qualified values are garbage outside their strobe
	assign cache_res = cache_ack ? cres : dtf_cres_t'(~cres);
	assign diag_code = diag_done ? 8'h01 : 8'hfe;
	assign med_err = 1'b0;
endmodule : dtf_back
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import dtf_pkg::*;
;
	logic CLK_SYS = 1'b0;
	logic NRST = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic pass_slave = 1'b1;
	logic [3:0] dly = 4'h2;
	dtf_cres_t cres = CR_HIT;
	logic is_slave = 1'b0;
	logic [31:0] PRDATA, rdat, n_med, n_seek, n_inv, n_we, n_fmt;
	logic PREADY, PSLVERR, INTRQ, MED_REQ, MED_DONE, MED_ERR, SEEK_REQ, SEEK_DONE, CACHE_INV, CACHE_QUERY;
	logic CACHE_ACK, BUF_WE, FMT_VALID, DIAG_REQ, DIAG_DONE, PASS_OUT, PASS_OE_N;
	dtf_cres_t CACHE_RES;
	dtf_fmt_t fact;
	logic [7:0] DIAG_CODE, SECTORS_PER_TRACK;
	logic [4:0] HEADS;
	int compares = 0;
	int miscompares = 0;
	int n_bad = 0;
	// Pulled-up pass line, low when either drive pulls it
	wire logic PASS_IN = (PASS_OE_N | PASS_OUT) & pass_slave;
	always #12.5 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS) begin
		if (FMT_VALID && fact == FMT_BAD) begin
			n_bad <= n_bad + 1;
		end
	end
	dtf_cmd #(.PASS_WAIT(200)) DUT (.CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .INTRQ, .JOB(), .MED_REQ, .MED_DONE, .MED_ERR, .SEEK_REQ, .SEEK_DONE, .CACHE_INV, .CACHE_QUERY,
		.CACHE_ACK, .CACHE_RES, .BUF_WE, .BUF_WADDR(), .BUF_WDATA(), .FMT_VALID, .FMT_ACTION(fact), .FMT_SECTOR(),
		.DIAG_REQ, .DIAG_DONE, .DIAG_CODE, .SECTORS_PER_TRACK, .HEADS, .PASS_IN, .PASS_OUT, .PASS_OE_N, .IS_SLAVE(is_slave));
	dtf_back u_back (.clk(CLK_SYS), .nrst(NRST), .dly, .cres, .med_req(MED_REQ), .seek_req(SEEK_REQ),
		.cache_query(CACHE_QUERY), .diag_req(DIAG_REQ), .cache_inv(CACHE_INV), .buf_we(BUF_WE),
		.fmt_valid(FMT_VALID), .med_done(MED_DONE), .med_err(MED_ERR), .seek_done(SEEK_DONE),
		.cache_ack(CACHE_ACK), .cache_res(CACHE_RES), .diag_done(DIAG_DONE), .diag_code(DIAG_CODE),
		.n_med, .n_seek, .n_inv, .n_we, .n_fmt);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {16'h0000, d};
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do
			@(posedge CLK_SYS);
		while (PREADY !== 1'b1);
		rdat = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic wr(input logic [5:0] i, input logic [15:0] d);
		apb(1'b1, {i, 2'b00}, d);
	endtask : wr
	task automatic rd(input logic [5:0] i);
		apb(1'b0, {i, 2'b00}, 16'h0000);
	endtask : rd
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			rd(IDX_STATUS);
			n++;
		end while (rdat[b] !== v && n < 900);
	endtask : poll
	task automatic wait_irq;
		int n;
		n = 0;
		while (INTRQ !== 1'b1 && n < 500) begin
			@(negedge CLK_SYS);
			n++;
		end
	endtask : wait_irq
	task automatic issue(input logic [7:0] cnt, input logic [7:0] cyl, input logic [7:0] drive_head_select_register, input logic [7:0] op);
		wr(IDX_SECCNT, {8'h00, cnt});
		wr(IDX_SECNUM, 16'h0001);
		wr(IDX_CYLLO, {8'h00, cyl});
		wr(IDX_CYLHI, 16'h0000);
		wr(IDX_SDH, {8'h00, drive_head_select_register});
		wr(IDX_STATUS, {8'h00, op});
	endtask : issue
	task automatic t_setp;
		rd(IDX_SDH);
		chk(rdat, 32'ha0);
		issue(8'h11, 8'h00, 8'ha3, OPC_SETP);
		poll(ST_BSY, 1'b0);
		chk(SECTORS_PER_TRACK, 8'h11);
		chk(HEADS, 5'h04);
		$display("t_setp end");
	endtask : t_setp
	task automatic t_seek;
		dly <= 4'hc;
		issue(8'h00, 8'h05, 8'ha0, 8'h7f);
		wait_irq();
		chk(INTRQ, 1'b1);
		rd(IDX_STATUS);
		chk(rdat[7:4], 4'h4);
		@(negedge CLK_SYS);
		chk(INTRQ, 1'b0);
		repeat (20) @(posedge CLK_SYS);
		rd(IDX_STATUS);
		chk(rdat[ST_SC], 1'b1);
		dly <= 4'h2;
		$display("t_seek end");
	endtask : t_seek
	task automatic t_write;
		logic [31:0] bw, bm, bs, bi;
		bw = n_we;
		bm = n_med;
		bs = n_seek;
		bi = n_inv;
		wr(IDX_DATA, 16'h1234);
		issue(8'h02, 8'h09, 8'ha1, 8'h31);
		chk(n_we - bw, 32'h0);
		poll(ST_DRQ, 1'b1);
		for (int s = 0; s < 2; s++) begin
			if (s == 1) begin
				wait_irq();
				chk(INTRQ, 1'b1);
				poll(ST_DRQ, 1'b1);
			end
			repeat (256) wr(IDX_DATA, 16'h5aa5);
		end
		poll(ST_BSY, 1'b0);
		chk(n_we - bw, 32'h200);
		chk(n_med - bm, 32'h2);
		chk(n_seek - bs, 32'h1);
		chk(n_inv - bi, 32'h1);
		$display("t_write end");
	endtask : t_write
	task automatic t_long;
		logic [31:0] bw;
		bw = n_we;
		issue(8'h01, 8'h09, 8'ha1, 8'h32);
		poll(ST_DRQ, 1'b1);
		repeat (258) wr(IDX_DATA, 16'hc3c3);
		poll(ST_BSY, 1'b0);
		chk(n_we - bw, 32'h102);
		issue(8'h02, 8'h09, 8'ha1, 8'h32);
		poll(ST_BSY, 1'b0);
		rd(IDX_ERROR);
		chk(rdat, ERR_ABORT);
		$display("t_long end");
	endtask : t_long
	task automatic t_verify;
		logic [31:0] bm;
		for (int r = 0; r < 4; r++) begin
			cres <= dtf_cres_t'(r[1:0]);
			bm = n_med;
			issue(8'h00, 8'h09, 8'ha1, 8'h41);
			poll(ST_BSY, 1'b0);
			chk(n_med - bm, (r == 0) ? 32'h0 : 32'h1);
		end
		$display("t_verify end");
	endtask : t_verify
	task automatic t_format;
		logic [7:0] fl [4] = '{FLAG_GOOD, FLAG_BAD, FLAG_UNASSIGN, FLAG_REASSIGN};
		logic [31:0] bf;
		int bb;
		bf = n_fmt;
		bb = n_bad;
		issue(8'h11, 8'h03, 8'ha0, OPC_FORMAT);
		poll(ST_DRQ, 1'b1);
		for (int i = 0; i < 256; i++)
			wr(IDX_DATA, (i < 17) ? {8'(i + 1), fl[i % 4]} : 16'h0000);
		wait_irq();
		chk(INTRQ, 1'b1);
		poll(ST_BSY, 1'b0);
		chk(n_fmt - bf, 32'h11);
		chk(n_bad - bb, 32'h4);
		bf = n_fmt;
		issue(8'h04, 8'h03, 8'he0, OPC_FORMAT);
		poll(ST_DRQ, 1'b1);
		for (int i = 0; i < 256; i++)
			wr(IDX_DATA, {8'(i + 1), FLAG_GOOD});
		poll(ST_BSY, 1'b0);
		chk(n_fmt - bf, 32'h4);
		issue(8'h10, 8'h03, 8'ha0, OPC_FORMAT);
		poll(ST_BSY, 1'b0);
		rd(IDX_ERROR);
		chk(rdat, ERR_ABORT);
		$display("t_format end");
	endtask : t_format
	task automatic t_diag;
		issue(8'h00, 8'h00, 8'hb0, OPC_DIAG);
		poll(ST_BSY, 1'b0);
		rd(IDX_ERROR);
		chk(rdat, 32'h81);
		rd(IDX_SDH);
		chk(rdat[SDH_DEV_BIT], 1'b0);
		pass_slave <= 1'b0;
		issue(8'h00, 8'h00, 8'ha0, OPC_DIAG);
		poll(ST_BSY, 1'b0);
		rd(IDX_ERROR);
		chk(rdat, DIAG_PASS);
		pass_slave <= 1'b1;
		is_slave <= 1'b1;
		issue(8'h00, 8'h00, 8'hb0, OPC_DIAG);
		poll(ST_BSY, 1'b0);
		chk(PASS_OE_N, 1'b0);
		rd(IDX_ERROR);
		chk(rdat, DIAG_PASS);
		$display("t_diag end");
	endtask : t_diag
	task automatic t_bad;
		issue(8'h00, 8'h00, 8'ha0, 8'hff);
		poll(ST_BSY, 1'b0);
		chk(rdat[ST_ERR], 1'b1);
		rd(IDX_ERROR);
		chk(rdat, ERR_ABORT);
		$display("t_bad end");
	endtask : t_bad
	task automatic stop_test;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	initial begin
		repeat (2) @(posedge CLK_SYS);
		NRST <= 1'b1;
		t_setp();
		t_seek();
		t_write();
		t_long();
		t_verify();
		t_format();
		t_bad();
		t_diag();
		stop_test();
	end
	initial begin
		#750000;
		miscompares++;
		stop_test();
	end
endmodule : tb
`default_nettype wire
